/* common/aux_ctrl_defs.svh */
// Behaviour
// - Five-bit select routes ADC to measured node
// - Select write of 0x00..0x11 starts conversion when idle; result readable after ADC done
// - ADC result passed to engines as variable
// - Overtemp stops boost, flashes, sets flag bit1
// - Restart automatically when overtemp indication clears
// - Config bit0 picks PWM or voltage-mode/sync
// - PWM minimum frequency selectable, four choices
// - Filter latency follows minimum frequency setting
// - PWM duty filtered into average, scales current
// - PWM acts only on enabled grouped outputs
// - PWM times brightness times light, mapped out
// - Alert low on sequence, zone, ADC done
// - Config bit1 makes alert pin ADC input
// - Trigger active low, input needs two cycles
// - Sent trigger is three slow cycles low
// - Trigger line only pulled low, open drain
// - External clock plus power-save stops internal
// - Internal clock serves when no external clock
// - Zone 3/4 targets read bit7 as one
// - Status read clears zone flag, releases alert
`ifndef AUX_CTRL_DEFS_SVH
`define AUX_CTRL_DEFS_SVH
`define ADDR_PWM_CTRL 8'h1D
`define ADDR_PIN_CFG 8'h3B
`define ADDR_STATUS 8'h3A
`define ADDR_FLAG 8'h3C
`define ADDR_ADC_SEL 8'h3D
`define ADDR_ADC_RESULT 8'h3E
`define ADDR_GROUP_CFG 8'h3F
`define ADDR_Z3_TARGET 8'h40
`define ADDR_Z4_TARGET 8'h41
`define PIN_CFG_PWM_BIT 0
`define PIN_CFG_ALERT_BIT 1
`define FLAG_TSD_BIT 1
`define STATUS_ZONE_BIT 0
`define STATUS_ENGINE_BIT 1
`define STATUS_ADC_BIT 2
`define ADC_SEL_VOUT 5'h0F
`define ADC_SEL_LIGHT_SENSOR_INPUT_ONE 5'h10
`define ADC_SEL_ALERT 5'h11
`define ADC_SEL_LAST 5'h11
`define ADC_SEL_RESET 5'h00
`define PWM_CTRL_RESET 8'h00
`define PIN_CFG_RESET 8'h00
`define TARGET_RESET 7'h00
`define SLOW_CLK_HZ 32768
`define REF_CLK_HZ 20000000
`define SLOW_DIV ((`REF_CLK_HZ + `SLOW_CLK_HZ / 2) / `SLOW_CLK_HZ)
`define SYNC_PULSE_LINE_N_IN_MIN_CYC 2
`define SYNC_PULSE_LINE_N_OUT_CYC 3
// Filter shift per minimum frequency: 100 Hz, 500 Hz, 1 kHz, 5 kHz
`define FILT_SHIFT_100 8
`define FILT_SHIFT_500 6
`define FILT_SHIFT_1K 5
`define FILT_SHIFT_5K 3
`endif

/* common/aux_ctrl_pkg.sv */
package aux_ctrl_pkg;
    typedef enum logic [1:0] {
        min_100hz,
        min_500hz,
        min_1khz,
        min_5khz
    } pwm_min_freq_t;
    typedef enum {
        adc_idle,
        adc_busy
    } adc_state_t;
endpackage

/* verilog/pwm_duty_filter.sv */
`timescale 1ns/1ps
`include "aux_ctrl_defs.svh"
module pwm_duty_filter #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Control
    input wire logic enable,
    input wire logic sample_en,
    input wire logic [1:0] min_freq,
    input wire logic pwm_in,
    // Result
    output logic [WIDTH-1:0] duty_avg
);
    initial begin
        if (WIDTH < 4 || WIDTH > 16) $error("pwm_duty_filter WIDTH out of range");
    end
    localparam int ACC_W = WIDTH + 8;
    logic [ACC_W-1:0] acc_q;
    logic [3:0] shift;
    logic [ACC_W-1:0] target;
    logic [ACC_W-1:0] step;
    // Shorter time constant for higher minimum frequency, so latency tracks setting
    // latency per setting
    always_comb begin
        case (aux_ctrl_pkg::pwm_min_freq_t'(min_freq))
            aux_ctrl_pkg::min_100hz: shift = 4'(`FILT_SHIFT_100);
            aux_ctrl_pkg::min_500hz: shift = 4'(`FILT_SHIFT_500);
            aux_ctrl_pkg::min_1khz: shift = 4'(`FILT_SHIFT_1K);
            aux_ctrl_pkg::min_5khz: shift = 4'(`FILT_SHIFT_5K);
            default: shift = 4'(`FILT_SHIFT_100);
        endcase
        target = pwm_in ? {ACC_W{1'b1}} : '0;
        step = (target >= acc_q) ? ((target - acc_q) >> shift) : ((acc_q - target) >> shift);
    end
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            acc_q <= '0;
        end else if (!enable) begin
            acc_q <= '0;
        end else if (sample_en) begin
            if (target >= acc_q) begin
                acc_q <= acc_q + ((step == '0 && target != acc_q) ? ACC_W'(1) : step);
            end else begin
                acc_q <= acc_q - ((step == '0) ? ACC_W'(1) : step);
            end
        end
    end
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            duty_avg <= '0;
        end else begin
            duty_avg <= acc_q[ACC_W-1 -: WIDTH];
        end
    end
endmodule

/* verilog/aux_pin_adc_select_control.sv */
`timescale 1ns/1ps
`include "aux_ctrl_defs.svh"
module aux_pin_adc_select_control #(
    parameter int GROUPS = 3,
    parameter int FILT_DIV = 64
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Register port from the serial interface
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // ADC
    output logic [4:0] adc_select,
    output logic adc_start,
    input wire logic adc_done,
    input wire logic [7:0] adc_data,
    output logic [7:0] engine_adc_var,
    // Events
    input wire logic engine_seq_done,
    input wire logic als_zone_change,
    // Thermal
    input wire logic over_temp,
    output logic boost_enable,
    output logic flash_source_one_en,
    output logic flash_source_two_en,
    // Shared pin
    input wire logic shared_pin_in,
    output logic pwm_in_enable,
    output logic ext_voltage_mode_enable,
    output logic pa_sync_input_two,
    // Group brightness
    input wire logic [8*GROUPS-1:0] group_brightness,
    input wire logic [8*GROUPS-1:0] als_level,
    output logic [8*GROUPS-1:0] group_current,
    // Alert pin, open drain
    output logic alert_n_o,
    output logic alert_n_oe,
    output logic alert_to_adc,
    // Trigger line, open drain
    input wire logic sync_pulse_line_n_i,
    output logic sync_pulse_line_n_o,
    output logic sync_pulse_line_n_oe,
    input wire logic sync_pulse_line_n_send,
    output logic sync_pulse_line_n_received,
    // Clocking
    input wire logic ext_clk_present,
    input wire logic power_save,
    output logic int_osc_enable
);
    initial begin
        if (GROUPS < 1 || GROUPS > 3) $error("GROUPS must be 1 to 3");
        if (FILT_DIV < 1) $error("FILT_DIV must be positive");
    end

    logic [7:0] pwm_ctrl_q;
    logic [7:0] pin_cfg_q;
    logic [7:0] group_cfg_q;
    logic [6:0] z3_target_q;
    logic [6:0] z4_target_q;
    logic [4:0] adc_sel_q;
    logic [7:0] adc_result_q;
    logic [2:0] status_q;
    logic tsd_flag_q;
    logic tsd_active_q;
    aux_ctrl_pkg::adc_state_t adc_state_q;
    logic wr_pwm, wr_cfg, wr_grp, wr_z3, wr_z4, wr_sel, rd_status, rd_flag;

    assign wr_pwm = reg_wr && reg_addr == `ADDR_PWM_CTRL;
    assign wr_cfg = reg_wr && reg_addr == `ADDR_PIN_CFG;
    assign wr_grp = reg_wr && reg_addr == `ADDR_GROUP_CFG;
    assign wr_z3 = reg_wr && reg_addr == `ADDR_Z3_TARGET;
    assign wr_z4 = reg_wr && reg_addr == `ADDR_Z4_TARGET;
    assign wr_sel = reg_wr && reg_addr == `ADDR_ADC_SEL;
    assign rd_status = reg_rd && reg_addr == `ADDR_STATUS;
    assign rd_flag = reg_rd && reg_addr == `ADDR_FLAG;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pwm_ctrl_q <= `PWM_CTRL_RESET;
            pin_cfg_q <= `PIN_CFG_RESET;
            group_cfg_q <= 8'h00;
            z3_target_q <= `TARGET_RESET;
            z4_target_q <= `TARGET_RESET;
        end else begin
            if (wr_pwm) pwm_ctrl_q <= reg_wdata;
            if (wr_cfg) pin_cfg_q <= reg_wdata;
            if (wr_grp) group_cfg_q <= reg_wdata;
            if (wr_z3) z3_target_q <= reg_wdata[6:0];
            if (wr_z4) z4_target_q <= reg_wdata[6:0];
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            adc_sel_q <= `ADC_SEL_RESET;
        end else if (wr_sel && reg_wdata[4:0] <= `ADC_SEL_LAST) begin
            adc_sel_q <= reg_wdata[4:0];
        end
    end
    assign adc_select = adc_sel_q;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            adc_state_q <= aux_ctrl_pkg::adc_idle;
            adc_start <= 1'b0;
            adc_result_q <= 8'h00;
            engine_adc_var <= 8'h00;
        end else begin
            adc_start <= 1'b0;
            case (adc_state_q)
                aux_ctrl_pkg::adc_idle: begin
                    if (wr_sel && reg_wdata[4:0] <= `ADC_SEL_LAST) begin
                        adc_start <= 1'b1;
                        adc_state_q <= aux_ctrl_pkg::adc_busy;
                    end
                end
                aux_ctrl_pkg::adc_busy: begin
                    if (adc_done) begin
                        adc_result_q <= adc_data;
                        engine_adc_var <= adc_data;
                        adc_state_q <= aux_ctrl_pkg::adc_idle;
                    end
                end
                default: adc_state_q <= aux_ctrl_pkg::adc_idle;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            status_q <= 3'h0;
        end else begin
            status_q[`STATUS_ZONE_BIT] <= als_zone_change ||
                (status_q[`STATUS_ZONE_BIT] && !rd_status);
            status_q[`STATUS_ENGINE_BIT] <= engine_seq_done ||
                (status_q[`STATUS_ENGINE_BIT] && !rd_status);
            status_q[`STATUS_ADC_BIT] <= (adc_state_q == aux_ctrl_pkg::adc_busy && adc_done) ||
                (status_q[`STATUS_ADC_BIT] && !rd_status);
        end
    end

    assign alert_to_adc = pin_cfg_q[`PIN_CFG_ALERT_BIT];
    assign alert_n_o = 1'b0;
    assign alert_n_oe = !alert_to_adc && (status_q != 3'h0);

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            tsd_active_q <= 1'b0;
            tsd_flag_q <= 1'b0;
        end else begin
            tsd_active_q <= over_temp;
            tsd_flag_q <= over_temp || (tsd_flag_q && !rd_flag);
        end
    end
    assign boost_enable = !tsd_active_q;
    assign flash_source_one_en = !tsd_active_q;
    assign flash_source_two_en = !tsd_active_q;

    assign pwm_in_enable = !pin_cfg_q[`PIN_CFG_PWM_BIT];
    assign ext_voltage_mode_enable = pin_cfg_q[`PIN_CFG_PWM_BIT] && shared_pin_in;
    assign pa_sync_input_two = pin_cfg_q[`PIN_CFG_PWM_BIT] && shared_pin_in;

    // Filter sample enable keeps accumulator compact
    logic [15:0] filt_cnt_q;
    logic filt_tick;
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            filt_cnt_q <= 16'h0000;
        end else if (filt_tick) begin
            filt_cnt_q <= 16'h0000;
        end else begin
            filt_cnt_q <= filt_cnt_q + 16'h0001;
        end
    end
    assign filt_tick = filt_cnt_q == 16'(FILT_DIV - 1);

    logic [7:0] duty_avg;
    pwm_duty_filter #(
        .WIDTH(8)
    ) u_filter (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .enable(pwm_in_enable),
        .sample_en(filt_tick),
        .min_freq(pwm_ctrl_q[1:0]),
        .pwm_in(shared_pin_in),
        .duty_avg(duty_avg)
    );

    // Group cfg: bits [2:0] PWM enable, bits [5:3] light enable per group
    genvar g;
    generate
        for (g = 0; g < GROUPS; g++) begin : gen_group
            logic [7:0] pwm_f;
            logic [7:0] als_f;
            logic [23:0] prod;
            assign pwm_f = (pwm_in_enable && group_cfg_q[g]) ? duty_avg : 8'hFF;
            assign als_f = group_cfg_q[g+3] ? als_level[8*g +: 8] : 8'hFF;
            assign prod = group_brightness[8*g +: 8] * pwm_f * als_f;
            always_ff @(posedge ref_clk or negedge nrst) begin
                if (!nrst) begin
                    group_current[8*g +: 8] <= 8'h00;
                end else begin
                    group_current[8*g +: 8] <= prod[23:16];
                end
            end
        end
    endgenerate

    // Slow 32 kHz enable from divider
    logic [9:0] slow_cnt_q;
    logic slow_tick;
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            slow_cnt_q <= 10'h000;
        end else if (slow_tick) begin
            slow_cnt_q <= 10'h000;
        end else begin
            slow_cnt_q <= slow_cnt_q + 10'h001;
        end
    end
    assign slow_tick = slow_cnt_q == 10'(`SLOW_DIV - 1);

    logic sync_pulse_line_n_s1_q, sync_pulse_line_n_s2_q;
    logic own_s1_q, own_s2_q;
    logic [1:0] low_cnt_q;
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            sync_pulse_line_n_s1_q <= 1'b1;
            sync_pulse_line_n_s2_q <= 1'b1;
            own_s1_q <= 1'b0;
            own_s2_q <= 1'b0;
        end else if (slow_tick) begin
            sync_pulse_line_n_s1_q <= sync_pulse_line_n_i;
            sync_pulse_line_n_s2_q <= sync_pulse_line_n_s1_q;
            // Own pulse delayed like the line, so its tail is not heard back
            own_s1_q <= sync_pulse_line_n_oe;
            own_s2_q <= own_s1_q;
        end
    end
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            low_cnt_q <= 2'd0;
            sync_pulse_line_n_received <= 1'b0;
        end else begin
            sync_pulse_line_n_received <= 1'b0;
            if (slow_tick) begin
                if (sync_pulse_line_n_s2_q || sync_pulse_line_n_oe || own_s2_q) begin
                    low_cnt_q <= 2'd0;
                end else if (low_cnt_q != 2'd3) begin
                    low_cnt_q <= low_cnt_q + 2'd1;
                    sync_pulse_line_n_received <= (low_cnt_q == 2'(`SYNC_PULSE_LINE_N_IN_MIN_CYC - 1));
                end
            end
        end
    end

    logic [1:0] send_cnt_q;
    logic send_pend_q;
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            send_cnt_q <= 2'd0;
            send_pend_q <= 1'b0;
        end else begin
            if (sync_pulse_line_n_send && send_cnt_q == 2'd0) send_pend_q <= 1'b1;
            if (slow_tick) begin
                if (send_cnt_q != 2'd0) begin
                    send_cnt_q <= send_cnt_q - 2'd1;
                end else if (send_pend_q) begin
                    send_cnt_q <= 2'(`SYNC_PULSE_LINE_N_OUT_CYC);
                    send_pend_q <= 1'b0;
                end
            end
        end
    end
    assign sync_pulse_line_n_o = 1'b0;
    assign sync_pulse_line_n_oe = send_cnt_q != 2'd0;

    assign int_osc_enable = !(ext_clk_present && power_save);

    always_comb begin
        case (reg_addr)
            `ADDR_PWM_CTRL: reg_rdata = pwm_ctrl_q;
            `ADDR_PIN_CFG: reg_rdata = pin_cfg_q;
            `ADDR_GROUP_CFG: reg_rdata = group_cfg_q;
            `ADDR_STATUS: reg_rdata = {5'h00, status_q};
            `ADDR_FLAG: reg_rdata = {6'h00, tsd_flag_q, 1'b0};
            `ADDR_ADC_SEL: reg_rdata = {3'h0, adc_sel_q};
            `ADDR_ADC_RESULT: reg_rdata = adc_result_q;
            `ADDR_Z3_TARGET: reg_rdata = {1'b1, z3_target_q};
            `ADDR_Z4_TARGET: reg_rdata = {1'b1, z4_target_q};
            default: reg_rdata = 8'h00;
        endcase
    end
endmodule

/* dv/aux_ctrl_checker_assertions.sv */
`timescale 1ns/1ps
`include "aux_ctrl_defs.svh"
module aux_ctrl_checker (
    // Clock, reset and register port
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic reg_wr,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    // ADC and thermal
    input wire logic [4:0] adc_select,
    input wire logic adc_start,
    input wire logic adc_done,
    input wire logic [7:0] adc_data,
    input wire logic [7:0] engine_adc_var,
    input wire logic over_temp,
    input wire logic boost_enable,
    input wire logic flash_source_one_en,
    input wire logic flash_source_two_en,
    // Pins
    input wire logic pwm_in_enable,
    input wire logic alert_n_o,
    input wire logic alert_n_oe,
    input wire logic alert_to_adc,
    input wire logic sync_pulse_line_n_o,
    input wire logic sync_pulse_line_n_oe
);
    int oe_len_q;
    default clocking dc @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    // Length of the pulse being sent
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            oe_len_q <= 0;
        end else begin
            oe_len_q <= sync_pulse_line_n_oe ? oe_len_q + 1 : 0;
        end
    end
    chk_pwm_select: assert property (
        reg_wr && reg_addr == `ADDR_PIN_CFG |=> pwm_in_enable == !$past(reg_wdata[0]))
        else $error("pin role not taken from bit 0");
    chk_start_cause: assert property (
        adc_start |-> $past(reg_wr && reg_addr == `ADDR_ADC_SEL && reg_wdata <= 8'h11)
            && adc_select == $past(reg_wdata[4:0]))
        else $error("conversion start without valid select write");
    chk_select_refuse: assert property (
        reg_wr && reg_addr == `ADDR_ADC_SEL && reg_wdata > 8'h11 |=> !adc_start)
        else $error("unused select code started a conversion");
    chk_engine_var: assert property (
        adc_done |=> engine_adc_var == $past(adc_data))
        else $error("engine variable misses conversion result");
    chk_thermal_off: assert property (
        over_temp |=> !boost_enable && !flash_source_one_en && !flash_source_two_en)
        else $error("power stages still on during overtemp");
    chk_thermal_restart: assert property (
        !over_temp |=> boost_enable && flash_source_one_en && flash_source_two_en)
        else $error("power stages stay off after overtemp");
    chk_alert_raise: assert property (
        adc_done && !alert_to_adc |=> alert_n_oe)
        else $error("alert not pulled on conversion done");
    chk_alert_as_adc: assert property (
        alert_to_adc |-> !alert_n_oe)
        else $error("alert driven while routed to ADC");
    chk_low_only: assert property (
        !sync_pulse_line_n_o && !alert_n_o)
        else $error("open drain pin drives high");
    chk_sync_pulse_line_n_width: assert property (
        $fell(sync_pulse_line_n_oe) |-> oe_len_q == `SYNC_PULSE_LINE_N_OUT_CYC * `SLOW_DIV)
        else $error("sent trigger has wrong length");
endmodule

bind aux_pin_adc_select_control aux_ctrl_checker u_chk (
    .ref_clk, .nrst, .reg_wr, .reg_addr, .reg_wdata, .adc_select, .adc_start,
    .adc_done, .adc_data, .engine_adc_var, .over_temp, .boost_enable,
    .flash_source_one_en, .flash_source_two_en, .pwm_in_enable, .alert_n_o,
    .alert_n_oe, .alert_to_adc, .sync_pulse_line_n_o, .sync_pulse_line_n_oe);

/* dv/far_side_model.sv */
`timescale 1ns/1ps
module far_side_model (
    // Clock
    input wire logic ref_clk,
    // Converter side
    input wire logic adc_start,
    input wire logic [4:0] adc_select,
    output logic adc_done,
    output logic [7:0] adc_data,
    // Trigger line, pulled up
    input wire logic dut_pull,
    output logic line_n
);
    logic peer_pull = 1'b0;
    logic [4:0] sel;
    int lat = 0;
    int starts = 0;
    assign line_n = !(dut_pull || peer_pull);
    initial begin
        adc_done = 1'b0;
        adc_data = 8'h5A;
    end
    always @(posedge ref_clk) begin
        if (adc_start === 1'b1) begin
            starts++;
            sel = adc_select;
            repeat (lat) @(posedge ref_clk);
            #1 adc_done = 1'b1;
            adc_data = {3'b101, sel};
            @(posedge ref_clk);
            #1 adc_done = 1'b0;
            adc_data = ~adc_data;
        end
    end
    task automatic pull(input int n);
        @(posedge ref_clk);
        #1 peer_pull = 1'b1;
        repeat (n) @(posedge ref_clk);
        #1 peer_pull = 1'b0;
    endtask
endmodule

/* dv/tb.sv */
`timescale 1ns/1ps
`include "aux_ctrl_defs.svh"
module tb;
    logic ref_clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, sync_pulse_line_n_send = 1'b0;
    logic engine_seq_done = 1'b0, als_zone_change = 1'b0, over_temp = 1'b0;
    logic shared_pin_in = 1'b0, ext_clk_present = 1'b0, power_save = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, adc_data, engine_adc_var;
    logic [23:0] group_brightness = 24'h808080, als_level = 24'h404040, group_current;
    logic [4:0] adc_select;
    logic adc_start, adc_done, boost_enable, flash_source_one_en, flash_source_two_en;
    logic pwm_in_enable, ext_voltage_mode_enable, pa_sync_input_two, alert_n_o, alert_n_oe;
    logic alert_to_adc, line_n, sync_pulse_line_n_o, sync_pulse_line_n_oe;
    logic sync_pulse_line_n_received, int_osc_enable;
    int n_errors = 0;
    int checked = 0;
    int n_rx = 0;
    int k;
    aux_pin_adc_select_control #(.FILT_DIV(1)) i_dut (
        .ref_clk, .nrst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
        .adc_select, .adc_start, .adc_done, .adc_data, .engine_adc_var,
        .engine_seq_done, .als_zone_change, .over_temp, .boost_enable,
        .flash_source_one_en, .flash_source_two_en, .shared_pin_in, .pwm_in_enable,
        .ext_voltage_mode_enable, .pa_sync_input_two, .group_brightness, .als_level,
        .group_current, .alert_n_o, .alert_n_oe, .alert_to_adc,
        .sync_pulse_line_n_i(line_n), .sync_pulse_line_n_o, .sync_pulse_line_n_oe,
        .sync_pulse_line_n_send, .sync_pulse_line_n_received, .ext_clk_present, .power_save, .int_osc_enable);
    far_side_model i_far (.ref_clk, .adc_start, .adc_select, .adc_done, .adc_data,
        .dut_pull(sync_pulse_line_n_oe), .line_n);
    always #25 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (sync_pulse_line_n_received === 1'b1) n_rx++;
    task automatic cmp(input string nm, input logic [23:0] e, input logic [23:0] g);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        #1 reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge ref_clk);
        #1 reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        #1 reg_rd = 1'b1;
        reg_addr = a;
        #40 cmp($sformatf("reg %h", a), 24'(e), 24'(reg_rdata));
        @(posedge ref_clk);
        #1 reg_rd = 1'b0;
    endtask
    task automatic stop_test;
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Whole run needs about 15k cycles
    initial begin
        #(40000 * 50);
        n_errors++;
        stop_test;
    end
    initial begin
        repeat (8) @(posedge ref_clk);
        #1 nrst = 1'b1;
        rd(`ADDR_PIN_CFG, 8'h00);
        rd(8'h55, 8'h00);
        for (int f = 0; f < 4; f++) begin
            wr(`ADDR_PWM_CTRL, 8'(f));
            rd(`ADDR_PWM_CTRL, 8'(f));
        end
        wr(`ADDR_Z3_TARGET, 8'h2A);
        rd(`ADDR_Z3_TARGET, 8'hAA);
        wr(`ADDR_Z4_TARGET, 8'h7F);
        rd(`ADDR_Z4_TARGET, 8'hFF);
        for (int c = 0; c <= 17; c++) begin
            i_far.lat = (c % 2) * 5;
            wr(`ADDR_ADC_SEL, 8'(c));
            cmp("select", 24'(c), 24'(adc_select));
            k = 0;
            while (alert_n_oe !== 1'b1 && k < 20) begin
                @(posedge ref_clk);
                #1 k++;
            end
            cmp("engine var", 24'(8'hA0 + c), 24'(engine_adc_var));
            rd(`ADDR_ADC_RESULT, 8'(8'hA0 + c));
            rd(`ADDR_STATUS, 8'h04);
            cmp("alert", 24'h0, 24'(alert_n_oe));
        end
        k = i_far.starts;
        wr(`ADDR_ADC_SEL, 8'h12);
        repeat (8) @(posedge ref_clk);
        #1 cmp("select", 24'h11, 24'(adc_select));
        cmp("starts", 24'(k), 24'(i_far.starts));
        shared_pin_in = 1'b1;
        wr(`ADDR_PIN_CFG, 8'h03);
        cmp("pin roles", 24'h7, 24'({pwm_in_enable, ext_voltage_mode_enable,
            pa_sync_input_two, alert_to_adc}));
        engine_seq_done = 1'b1;
        als_zone_change = 1'b1;
        @(posedge ref_clk);
        #1 engine_seq_done = 1'b0;
        als_zone_change = 1'b0;
        cmp("alert", 24'h0, 24'(alert_n_oe));
        wr(`ADDR_PIN_CFG, 8'h00);
        cmp("alert", 24'h1, 24'(alert_n_oe));
        rd(`ADDR_STATUS, 8'h03);
        cmp("alert", 24'h0, 24'(alert_n_oe));
        over_temp = 1'b1;
        repeat (2) @(posedge ref_clk);
        #1 cmp("power", 24'h0, 24'({boost_enable, flash_source_one_en,
            flash_source_two_en}));
        rd(`ADDR_FLAG, 8'h02);
        over_temp = 1'b0;
        repeat (2) @(posedge ref_clk);
        #1 cmp("power", 24'h7, 24'({boost_enable, flash_source_one_en,
            flash_source_two_en}));
        rd(`ADDR_FLAG, 8'h02);
        rd(`ADDR_FLAG, 8'h00);
        shared_pin_in = 1'b0;
        wr(`ADDR_GROUP_CFG, 8'h11);
        repeat (2000) @(posedge ref_clk);
        #1 cmp("current", 24'h7F1F, 24'(group_current[23:8]));
        cmp("pwm low", 24'h1, 24'(group_current[7:0] < 8'h10));
        shared_pin_in = 1'b1;
        repeat (2000) @(posedge ref_clk);
        #1 cmp("pwm high", 24'h1, 24'(group_current[7:0] > 8'h60));
        i_far.pull(500);
        repeat (2000) @(posedge ref_clk);
        cmp("rx", 24'h0, 24'(n_rx));
        i_far.pull(3 * `SLOW_DIV);
        repeat (2000) @(posedge ref_clk);
        cmp("rx", 24'h1, 24'(n_rx));
        #1 sync_pulse_line_n_send = 1'b1;
        @(posedge ref_clk);
        #1 sync_pulse_line_n_send = 1'b0;
        k = 0;
        while (line_n !== 1'b0 && k < 2000) begin
            @(posedge ref_clk);
            #1 k++;
        end
        k = 0;
        while (line_n === 1'b0 && k < 5000) begin
            @(posedge ref_clk);
            #1 k++;
        end
        cmp("sync_pulse_line_n len", 24'(`SYNC_PULSE_LINE_N_OUT_CYC * `SLOW_DIV), 24'(k));
        repeat (2000) @(posedge ref_clk);
        cmp("rx", 24'h1, 24'(n_rx));
        for (int m = 0; m < 4; m++) begin
            #1 ext_clk_present = m[0];
            power_save = m[1];
            @(posedge ref_clk);
            #1 cmp("osc", 24'(m != 3), 24'(int_osc_enable));
        end
        stop_test;
    end
endmodule
